// File: hdl/pxvt_cfg.svh
`ifndef PXVT_CFG_SVH
`define PXVT_CFG_SVH

// ----------------------------------------------------------------
// index offsets in the extended indexed space
// ----------------------------------------------------------------
`define PXVT_IDX_TFT_HRE        8'hb5
`define PXVT_IDX_L480_VT        8'hb6
`define PXVT_IDX_L480_VDE       8'hb7
`define PXVT_IDX_L480_VBS       8'hb8
`define PXVT_IDX_L480_VBE       8'hb9
`define PXVT_IDX_L480_VRS       8'hba
`define PXVT_IDX_L480_VRE       8'hbb
`define PXVT_IDX_L480_OVF       8'hbc
`define PXVT_IDX_L350_VCTR      8'hc0
`define PXVT_IDX_L400_VCTR      8'hc1
`define PXVT_IDX_L480_VCTR      8'hc2
`define PXVT_IDX_HALF_LO        8'hc3
`define PXVT_IDX_HALF_HI        8'hc4
`define PXVT_IDX_TEXT_HCTR      8'hc5
`define PXVT_IDX_GFX_HCTR       8'hc6
`define PXVT_IDX_L600_VT        8'hc7
`define PXVT_IDX_L600_VDE       8'hc8
`define PXVT_IDX_L600_VBS       8'hc9
`define PXVT_IDX_L600_VBE       8'hca
`define PXVT_IDX_L600_VRS       8'hcb
`define PXVT_IDX_L600_VRE       8'hcc
`define PXVT_IDX_L600_OVF       8'hcd
`define PXVT_IDX_L400_VT        8'hf0
`define PXVT_IDX_RSVD_F1        8'hf1
`define PXVT_IDX_L400_VBS       8'hf2
`define PXVT_IDX_L400_VBE       8'hf3
`define PXVT_IDX_L400_VRS       8'hf4
`define PXVT_IDX_L400_VRE       8'hf5
`define PXVT_IDX_L400_OVF       8'hf6
`define PXVT_IDX_L350_VT        8'hf7
`define PXVT_IDX_RSVD_F8        8'hf8
`define PXVT_IDX_L350_VBS       8'hf9
`define PXVT_IDX_L350_VBE       8'hfa
`define PXVT_IDX_L350_VRS       8'hfb
`define PXVT_IDX_L350_VRE       8'hfc
`define PXVT_IDX_L350_OVF       8'hfd

// ----------------------------------------------------------------
// slot bases of the three index runs
// ----------------------------------------------------------------
`define PXVT_RUN0_LAST          8'hbc
`define PXVT_RUN1_FIRST         8'hc0
`define PXVT_RUN1_LAST          8'hcd
`define PXVT_RUN2_FIRST         8'hf0
`define PXVT_RUN2_LAST          8'hfd
`define PXVT_SLOT_RUN1          6'd8
`define PXVT_SLOT_RUN2          6'd22
`define PXVT_NUM_SLOTS          36

// ----------------------------------------------------------------
// field positions and reset value
// ----------------------------------------------------------------
`define PXVT_OVF_VT_HI          1:0
`define PXVT_OVF_VDE_HI         3:2
`define PXVT_OVF_VBS_HI         5:4
`define PXVT_OVF_VRS_HI         7:6
`define PXVT_VRE_FLD            3:0
`define PXVT_TFT_HRE_FLD        4:0
`define PXVT_TFT_SKEW_FLD       7:5
`define PXVT_HCTR_FLD           3:0
`define PXVT_HALF_HI_BIT        0
`define PXVT_RST_VAL            8'h00

// ----------------------------------------------------------------
// programmed-value offsets
// ----------------------------------------------------------------
`define PXVT_VT_ADJ             10'h002
`define PXVT_VDE_ADJ            10'h001
`define PXVT_VBS_ADJ            10'h001

`endif

// File: hdl/pxvt_pkg.sv
package pxvt_pkg;

    typedef enum logic [2:0] {
        PXVT_GRP_STD = 3'b000,
        PXVT_GRP_350 = 3'b001,
        PXVT_GRP_400 = 3'b010,
        PXVT_GRP_480 = 3'b011,
        PXVT_GRP_600 = 3'b100
    } pxvt_grp_t;

    typedef enum logic [1:0] {
        PXVT_MISC_RSVD = 2'b00,
        PXVT_MISC_400  = 2'b01,
        PXVT_MISC_350  = 2'b10,
        PXVT_MISC_AUX  = 2'b11
    } pxvt_misc_t;

endpackage

// File: hdl/pxvt_timing.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - each vertical total low byte plus its overflow bits 1:0 is the line count minus two.
// RULE2 - the display end low byte is the active line count minus one, with overflow bits 3:2 as bits 9:8 for the 480 and 600 groups in expansion mode.
// RULE3 - the blank start low byte is the blank start line minus one, with bits 9:8 from overflow bits 5:4.
// RULE4 - the 8-bit blank end of each group is used as programmed, with no offset.
// RULE5 - retrace start is ten bits, low byte from its register and bits 9:8 from overflow bits 7:6, with no offset.
// RULE6 - only bits 3:0 of each retrace end register are compared; bits 7:4 are reserved.
// RULE7 - each overflow register holds total bits 9:8 at 1:0 and blank start bits 9:8 at 5:4.
// RULE8 - the 400 and 350 groups have no display end register and their overflow bits 3:2 are unused.
// RULE9 - the TFT register gives a 5-bit horizontal retrace end in 4:0 and a 3-bit skew in 7:5.
// RULE10 - in 350, 400 and 480 modes the picture is pushed down by that mode's 8-bit shift.
// RULE11 - the picture is shifted sideways by a 4-bit character count, one for text and one for graphics.
// RULE12 - a 9-bit half panel size, low byte plus bit 0 of the next register, marks the dual-panel split.
// RULE13 - hardware reset clears every register to zero.
// RULE14 - every register is read and written through the indexed data port.
// RULE15 - with the extended enable set, misc output bits 7:6 pick the extended group, else the standard set runs.
// RULE16 - the chosen group is assembled into 10-bit values and compared with the line counter to give blank, sync and display enable.
`include "pxvt_cfg.svh"

module pxvt_timing
    import pxvt_pkg::*;
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // indexed data port
    input  wire logic [7:0] i_io_index,
    input  wire logic       i_io_wr,
    input  wire logic       i_io_rd,
    input  wire logic [7:0] i_io_wdata,
    output logic      [7:0] o_io_rdata,
    output logic            o_io_hit,
    // mode controls
    input  wire logic       i_ext_vtiming_en,
    input  wire logic [1:0] i_misc_out_sel,
    input  wire logic       i_aux_sel_600,
    input  wire logic       i_vexp_mode,
    input  wire logic       i_text_mode,
    // standard vertical set
    input  wire logic [9:0] i_std_vtotal,
    input  wire logic [9:0] i_std_vdisp_end,
    input  wire logic [9:0] i_std_vblank_start,
    input  wire logic [7:0] i_std_vblank_end,
    input  wire logic [9:0] i_std_vretrace_start,
    input  wire logic [3:0] i_std_vretrace_end,
    // line timing
    input  wire logic       i_line_start,
    output logic            o_vblank,
    output logic            o_vsync,
    output logic            o_vde,
    output logic            o_lower_half,
    output logic      [9:0] o_line,
    // panel side controls
    output logic      [4:0] o_tft_hretrace_end,
    output logic      [2:0] o_tft_hretrace_skew,
    output logic      [3:0] o_hshift_chars,
    output logic      [8:0] o_half_panel_size
);

    // ----------------------------------------------------------------
    // index decode
    // ----------------------------------------------------------------
    function automatic logic slot_hit(input logic [7:0] idx);
        slot_hit = (idx >= `PXVT_IDX_TFT_HRE && idx <= `PXVT_RUN0_LAST) ||
                   (idx >= `PXVT_RUN1_FIRST && idx <= `PXVT_RUN1_LAST) ||
                   (idx >= `PXVT_RUN2_FIRST && idx <= `PXVT_RUN2_LAST);
    endfunction

    function automatic logic [5:0] slot_of(input logic [7:0] idx);
        logic [7:0] d;
        d = 8'h00;
        if (idx >= `PXVT_RUN2_FIRST) begin
            d = idx - `PXVT_RUN2_FIRST;
            slot_of = `PXVT_SLOT_RUN2 + d[5:0];
        end else if (idx >= `PXVT_RUN1_FIRST) begin
            d = idx - `PXVT_RUN1_FIRST;
            slot_of = `PXVT_SLOT_RUN1 + d[5:0];
        end else begin
            d = idx - `PXVT_IDX_TFT_HRE;
            slot_of = d[5:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] regs_r [0:`PXVT_NUM_SLOTS-1];
    logic       hit;

    assign hit = slot_hit(i_io_index);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int k = 0; k < `PXVT_NUM_SLOTS; k++) begin
                regs_r[k] <= `PXVT_RST_VAL; // RULE13
            end
        end else if (i_io_wr && hit) begin
            regs_r[slot_of(i_io_index)] <= i_io_wdata; // RULE14
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_io_rdata <= 8'h00;
            o_io_hit   <= 1'b0;
        end else begin
            o_io_hit <= hit;
            if (i_io_rd) begin
                o_io_rdata <= hit ? regs_r[slot_of(i_io_index)] : 8'h00; // RULE14
            end
        end
    end

    // ----------------------------------------------------------------
    // group selection
    // ----------------------------------------------------------------
    pxvt_grp_t grp;

    always_comb begin
        grp = PXVT_GRP_STD;
        if (i_ext_vtiming_en) begin // RULE15
            case (pxvt_misc_t'(i_misc_out_sel))
                PXVT_MISC_400: begin
                    grp = PXVT_GRP_400;
                end
                PXVT_MISC_350: begin
                    grp = PXVT_GRP_350;
                end
                PXVT_MISC_AUX: begin
                    grp = i_aux_sel_600 ? PXVT_GRP_600 : PXVT_GRP_480;
                end
                default: begin
                    grp = PXVT_GRP_STD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // field assembly
    // ----------------------------------------------------------------
    function automatic logic [7:0] rg(input logic [7:0] idx);
        rg = regs_r[slot_of(idx)];
    endfunction

    logic [9:0] vt_raw;
    logic [9:0] vde_raw;
    logic [9:0] vbs_raw;
    logic [7:0] vbe;
    logic [9:0] vrs;
    logic [3:0] vre;
    logic [7:0] vshift;
    logic [7:0] ovf;
    logic [7:0] lo_vt;
    logic [7:0] lo_vbs;
    logic [7:0] lo_vrs;

    always_comb begin
        ovf     = 8'h00;
        lo_vt   = 8'h00;
        lo_vbs  = 8'h00;
        lo_vrs  = 8'h00;
        vbe     = i_std_vblank_end;
        vre     = i_std_vretrace_end;
        vde_raw = i_std_vdisp_end;
        vshift  = 8'h00;
        case (grp)
            PXVT_GRP_350: begin
                ovf    = rg(`PXVT_IDX_L350_OVF);
                lo_vt  = rg(`PXVT_IDX_L350_VT);
                lo_vbs = rg(`PXVT_IDX_L350_VBS);
                lo_vrs = rg(`PXVT_IDX_L350_VRS);
                vbe    = rg(`PXVT_IDX_L350_VBE);
                vre    = 4'(rg(`PXVT_IDX_L350_VRE)); // RULE6
                vshift = rg(`PXVT_IDX_L350_VCTR);
            end
            PXVT_GRP_400: begin
                ovf    = rg(`PXVT_IDX_L400_OVF);
                lo_vt  = rg(`PXVT_IDX_L400_VT);
                lo_vbs = rg(`PXVT_IDX_L400_VBS);
                lo_vrs = rg(`PXVT_IDX_L400_VRS);
                vbe    = rg(`PXVT_IDX_L400_VBE);
                vre    = 4'(rg(`PXVT_IDX_L400_VRE)); // RULE6
                vshift = rg(`PXVT_IDX_L400_VCTR);
            end
            PXVT_GRP_480: begin
                ovf     = rg(`PXVT_IDX_L480_OVF);
                lo_vt   = rg(`PXVT_IDX_L480_VT);
                lo_vbs  = rg(`PXVT_IDX_L480_VBS);
                lo_vrs  = rg(`PXVT_IDX_L480_VRS);
                vbe     = rg(`PXVT_IDX_L480_VBE);
                vre     = 4'(rg(`PXVT_IDX_L480_VRE)); // RULE6
                vshift  = rg(`PXVT_IDX_L480_VCTR);
                vde_raw = {i_vexp_mode ? ovf[`PXVT_OVF_VDE_HI] : 2'b00, rg(`PXVT_IDX_L480_VDE)}; // RULE2
            end
            PXVT_GRP_600: begin
                ovf     = rg(`PXVT_IDX_L600_OVF);
                lo_vt   = rg(`PXVT_IDX_L600_VT);
                lo_vbs  = rg(`PXVT_IDX_L600_VBS);
                lo_vrs  = rg(`PXVT_IDX_L600_VRS);
                vbe     = rg(`PXVT_IDX_L600_VBE); // RULE4
                vre     = 4'(rg(`PXVT_IDX_L600_VRE)); // RULE6
                vde_raw = {i_vexp_mode ? ovf[`PXVT_OVF_VDE_HI] : 2'b00, rg(`PXVT_IDX_L600_VDE)}; // RULE2
            end
            default: begin
                vshift = 8'h00;
            end
        endcase
        // 350 and 400 groups keep the standard display end and ignore ovf 3:2
        if (grp == PXVT_GRP_STD) begin // RULE8
            vt_raw  = i_std_vtotal;
            vbs_raw = i_std_vblank_start;
            vrs     = i_std_vretrace_start;
        end else begin
            vt_raw  = {ovf[`PXVT_OVF_VT_HI], lo_vt};   // RULE1 RULE7
            vbs_raw = {ovf[`PXVT_OVF_VBS_HI], lo_vbs}; // RULE3 RULE7
            vrs     = {ovf[`PXVT_OVF_VRS_HI], lo_vrs}; // RULE5
        end
    end

    logic [9:0] last_line;
    logic [9:0] vbs_line;
    logic [9:0] de_first;
    logic [9:0] de_last;

    // total lines = raw + 2, so the last 0-based line is raw + 1
    assign last_line = vt_raw + `PXVT_VT_ADJ - 10'h001; // RULE1
    assign vbs_line  = vbs_raw + `PXVT_VBS_ADJ;         // RULE3
    assign de_first  = {2'b00, vshift};                  // RULE10
    assign de_last   = vde_raw + {2'b00, vshift};        // RULE10 RULE2

    // ----------------------------------------------------------------
    // line counter and vertical outputs
    // ----------------------------------------------------------------
    logic [9:0] line_r;
    logic [9:0] line_nxt;
    logic [8:0] half_size;

    assign line_nxt  = (line_r >= last_line) ? 10'h000 : line_r + 10'h001; // RULE16

    logic [7:0] half_lo_b;
    logic [7:0] half_hi_b;
    logic [7:0] tft_b;
    logic [7:0] text_ctr_b;
    logic [7:0] gfx_ctr_b;

    // whole register bytes, fields are cut from these
    always_comb begin
        half_lo_b  = rg(`PXVT_IDX_HALF_LO);
        half_hi_b  = rg(`PXVT_IDX_HALF_HI);
        tft_b      = rg(`PXVT_IDX_TFT_HRE);
        text_ctr_b = rg(`PXVT_IDX_TEXT_HCTR);
        gfx_ctr_b  = rg(`PXVT_IDX_GFX_HCTR);
    end

    assign half_size = {half_hi_b[`PXVT_HALF_HI_BIT], half_lo_b}; // RULE12

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            line_r <= 10'h000;
        end else if (i_line_start) begin
            line_r <= line_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vblank <= 1'b0;
            o_vsync  <= 1'b0;
        end else if (i_line_start) begin
            if (line_nxt == vbs_line) begin
                o_vblank <= 1'b1; // RULE16
            end else if (line_nxt[7:0] == vbe) begin
                o_vblank <= 1'b0; // RULE4
            end
            if (line_nxt == vrs) begin
                o_vsync <= 1'b1; // RULE5
            end else if (line_nxt[3:0] == vre[`PXVT_VRE_FLD]) begin
                o_vsync <= 1'b0; // RULE6
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vde        <= 1'b0;
            o_lower_half <= 1'b0;
            o_line       <= 10'h000;
        end else begin
            o_vde        <= (line_r >= de_first) && (line_r <= de_last); // RULE16 RULE10
            o_lower_half <= (line_r > {1'b0, half_size});                // RULE12
            o_line       <= line_r;
        end
    end

    // ----------------------------------------------------------------
    // panel side controls
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tft_hretrace_end  <= 5'h00;
            o_tft_hretrace_skew <= 3'h0;
            o_hshift_chars      <= 4'h0;
            o_half_panel_size   <= 9'h000;
        end else begin
            o_tft_hretrace_end  <= tft_b[`PXVT_TFT_HRE_FLD];  // RULE9
            o_tft_hretrace_skew <= tft_b[`PXVT_TFT_SKEW_FLD]; // RULE9
            o_hshift_chars      <= i_text_mode ? text_ctr_b[`PXVT_HCTR_FLD]
                                               : gfx_ctr_b[`PXVT_HCTR_FLD]; // RULE11
            o_half_panel_size   <= half_size; // RULE12
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_wr_hit;
        i_io_wr && hit && !i_io_rd;
    endsequence

    sequence s_rd_same;
        i_io_rd && !i_io_wr && hit;
    endsequence

    property p_wr_then_rd;
        logic [7:0] d;
        logic [7:0] x;
        (s_wr_hit, d = i_io_wdata, x = i_io_index) ##1 (s_rd_same and (i_io_index == x)) |=> (o_io_rdata == d);
    endproperty
    a_wr_then_rd: assert property (p_wr_then_rd) else $error("readback differs from written byte"); // RULE14

    property p_unmapped_zero;
        i_io_rd && !hit |=> o_io_rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped index read not zero"); // RULE14

    property p_wrap;
        i_line_start && line_r >= last_line |=> line_r == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("line counter missed wrap"); // RULE1

    property p_count;
        i_line_start && line_r < last_line |=> line_r == $past(line_r) + 10'h001;
    endproperty
    a_count: assert property (p_count) else $error("line counter did not advance"); // RULE16

    property p_blank_start;
        i_line_start && line_nxt == vbs_line |=> o_vblank;
    endproperty
    a_blank_start: assert property (p_blank_start) else $error("blank did not start"); // RULE3

    property p_sync_start;
        i_line_start && line_nxt == vrs |=> o_vsync;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync did not start"); // RULE5

    property p_sync_end;
        i_line_start && line_nxt != vrs && line_nxt[3:0] == vre |=> !o_vsync;
    endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync did not end"); // RULE6

    property p_vde;
        o_vde |-> ($past(line_r) >= $past(de_first)) && ($past(line_r) <= $past(de_last));
    endproperty
    a_vde: assert property (p_vde) else $error("display enable outside window"); // RULE10

    property p_std_when_off;
        !i_ext_vtiming_en |-> grp == PXVT_GRP_STD;
    endproperty
    a_std_when_off: assert property (p_std_when_off) else $error("extended group used while disabled"); // RULE15

    property p_skew;
        ##1 o_tft_hretrace_skew == $past(regs_r[0][7:5]);
    endproperty
    a_skew: assert property (p_skew) else $error("tft skew mismatch"); // RULE9

endmodule

// File: verification/pxvt_panel_model.sv
`timescale 1ns/1ps
// ------
// panel side line pacing
// ------
module pxvt_panel_model (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // pacing control
    input  wire logic       i_run,
    input  wire logic [3:0] i_gap,
    // line pulse and settle strobe
    output logic            o_line_start,
    output logic            o_sample
);
    logic [4:0] cnt_r;

    // one line pulse every gap+4 cycles, strobe once outputs settle
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r        <= 5'h00;
            o_line_start <= 1'b0;
            o_sample     <= 1'b0;
        end else begin
            o_line_start <= i_run && (cnt_r == 5'h00);
            o_sample     <= (cnt_r == {1'b0, i_gap} + 5'h02);
            if (i_run && (cnt_r == 5'h00)) begin
                cnt_r <= {1'b0, i_gap} + 5'h03;
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end
        end
    end
endmodule

// File: verification/pxvt_timing_tb.sv
`timescale 1ns/1ps
module pxvt_timing_tb;
    logic        clk, nrst, wr, rd, ext, aux, vexp, txt, run;
    logic [7:0]  idx, wdata, rdata;
    logic [1:0]  misc;
    logic [3:0]  gap, hsh, std_vre;
    logic        hit, ls, smp, vb_o, vs_o, vde_o, low_o;
    logic [9:0]  line_o, std_vt, std_vde, std_vbs, std_vrs;
    logic [7:0]  std_vbe;
    logic [4:0]  hre;
    logic [2:0]  skew;
    logic [8:0]  half;
    logic [31:0] seed, r;
    logic [7:0]  mem [36];
    int          num_errors, compares, cyc;

    pxvt_timing pxvt_timing_inst (
        .i_core_clk(clk), .i_nrst(nrst), .i_io_index(idx), .i_io_wr(wr), .i_io_rd(rd),
        .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_hit(hit), .i_ext_vtiming_en(ext),
        .i_misc_out_sel(misc), .i_aux_sel_600(aux), .i_vexp_mode(vexp), .i_text_mode(txt),
        .i_std_vtotal(std_vt), .i_std_vdisp_end(std_vde), .i_std_vblank_start(std_vbs),
        .i_std_vblank_end(std_vbe), .i_std_vretrace_start(std_vrs), .i_std_vretrace_end(std_vre),
        .i_line_start(ls), .o_vblank(vb_o), .o_vsync(vs_o), .o_vde(vde_o), .o_lower_half(low_o),
        .o_line(line_o), .o_tft_hretrace_end(hre), .o_tft_hretrace_skew(skew),
        .o_hshift_chars(hsh), .o_half_panel_size(half));

    pxvt_panel_model pxvt_panel_model_inst (
        .i_core_clk(clk), .i_nrst(nrst), .i_run(run), .i_gap(gap), .o_line_start(ls), .o_sample(smp));

    // ------
    // helpers
    // ------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] slot(input int k);
        return k < 8 ? 8'hb5 + 8'(k) : (k < 22 ? 8'hb8 + 8'(k) : 8'hda + 8'(k));
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        return (i >= 8'hb5 && i <= 8'hbc) || (i >= 8'hc0 && i <= 8'hcd) || (i >= 8'hf0 && i <= 8'hfd);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        #1;
        idx = i;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic rreg(input logic [7:0] i, input logic [7:0] exp);
        @(posedge clk);
        #1;
        idx = i;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        check(16'(rdata), 16'(exp));
        check(16'(hit), 16'(mapped(i)));
    endtask

    task automatic do_reset();
        run = 1'b0;
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
    endtask

    task automatic zero_all();
        for (int k = 0; k < 36; k++)
            rreg(slot(k), 8'h00);
    endtask

    // ------
    // frame run of one vertical group
    // ------
    task automatic run_frame(input logic [7:0] base, input logic [7:0] ctr, input logic [1:0] m,
                             input logic a, input logic e, input logic v);
        logic [9:0] vt, bs, rs, de, n;
        logic [7:0] be, sh;
        logic [3:0] re;
        logic       sd, vb, vs;
        do_reset();
        sd = !e || (m == 2'b00);
        std_vde = {2'b00, 8'(rnd())};
        ext = e;
        misc = m;
        aux = a;
        vexp = v;
        gap = 4'(rnd()) & 4'h3;
        wreg(base, 8'h2c);
        wreg(base + 8'h01, 8'h00);
        wreg(base + 8'h02, 8'h04);
        wreg(base + 8'h03, 8'h10);
        wreg(base + 8'h04, 8'h0a);
        wreg(base + 8'h05, 8'ha5);
        wreg(base + 8'h06, 8'h55);
        if (ctr != 8'h00)
            wreg(ctr, 8'h03);
        wreg(8'hc3, 8'h96);
        wreg(8'hc4, 8'hfe);
        vt = sd ? std_vt : 10'h12c;
        bs = sd ? std_vbs : 10'h104;
        be = sd ? std_vbe : 8'h10;
        rs = sd ? std_vrs : 10'h10a;
        re = sd ? std_vre : 4'h5;
        sh = (sd || ctr == 8'h00) ? 8'h00 : 8'h03;
        de = (sd || base >= 8'hf0) ? std_vde : (v ? 10'h100 : 10'h000);
        n = 10'h000;
        vb = 1'b0;
        vs = 1'b0;
        run = 1'b1;
        repeat (2 * (int'(vt) + 2)) begin
            @(negedge clk);
            repeat (20) if (!smp) @(negedge clk);
            n = (n == vt + 10'h001) ? 10'h000 : n + 10'h001;
            if (n == bs + 10'h001)
                vb = 1'b1;
            else if (n[7:0] == be)
                vb = 1'b0;
            if (n == rs)
                vs = 1'b1;
            else if (n[3:0] == re)
                vs = 1'b0;
            check(16'(line_o), 16'(n));
            check(16'(vb_o), 16'(vb));
            check(16'(vs_o), 16'(vs));
            check(16'(vde_o), 16'((n >= 10'(sh)) && (n <= de + 10'(sh))));
            check(16'(low_o), 16'(n > 10'h096));
        end
        @(posedge clk);
        #1;
        run = 1'b0;
    endtask

    // ------
    // clock, timeout and main sequence
    // ------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        {nrst, wr, rd, ext, aux, vexp, txt, run, misc, gap, idx, wdata} = '0;
        {std_vt, std_vde, std_vbs, std_vrs} = {10'h0c8, 10'h050, 10'h060, 10'h064};
        std_vbe = 8'h70;
        std_vre = 4'h8;
        seed = 32'd44;
        do_reset();
        zero_all();
        for (int k = 0; k < 36; k++) begin
            mem[k] = 8'(rnd());
            wreg(slot(k), mem[k]);
        end
        for (int k = 0; k < 36; k++)
            rreg(slot(k), mem[k]);
        wreg(8'hbd, 8'hff);
        rreg(8'hbd, 8'h00);
        r = rnd();
        @(posedge clk);
        #1;
        idx = 8'hc7;
        wdata = r[7:0];
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        check(16'(rdata), 16'(r[7:0]));
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wreg(8'hb5, r[7:0]);
            wreg(8'hc5, r[15:8]);
            wreg(8'hc6, r[23:16]);
            wreg(8'hc3, r[31:24]);
            wreg(8'hc4, r[7:0]);
            txt = r[0];
            @(posedge clk);
            #1;
            check(16'(hre), 16'(r[4:0]));
            check(16'(skew), 16'(r[7:5]));
            check(16'(hsh), 16'(txt ? r[11:8] : r[19:16]));
            check(16'(half), 16'({r[0], r[31:24]}));
        end
        txt = !txt;
        @(posedge clk);
        #1;
        check(16'(hsh), 16'(txt ? r[11:8] : r[19:16]));
        do_reset();
        zero_all();
        run_frame(8'hb6, 8'hc2, 2'b11, 1'b0, 1'b1, 1'b1);
        run_frame(8'hc7, 8'h00, 2'b11, 1'b1, 1'b1, 1'b0);
        run_frame(8'hf0, 8'hc1, 2'b01, 1'b0, 1'b1, 1'b1);
        run_frame(8'hf7, 8'hc0, 2'b10, 1'b0, 1'b1, 1'b1);
        run_frame(8'hc7, 8'h00, 2'b11, 1'b1, 1'b0, 1'b1);
        run_frame(8'hf0, 8'h00, 2'b00, 1'b0, 1'b1, 1'b1);
        end_sim();
    end
endmodule
